//--- common/adc_serial_defines.svh
// timing, widths and codes for the converter serial interface
// assumes a single 25 mhz system clock
`ifndef ADC_SERIAL_DEFINES_SVH
`define ADC_SERIAL_DEFINES_SVH

`define ADC_MCLK_MHZ 25
// longest conversion phase, in ns
`define ADC_T_CONV_NS 2200
// conversion phase length in clock cycles, rounded up
`define ADC_CONV_CYC ((`ADC_T_CONV_NS * `ADC_MCLK_MHZ + 999) / 1000)
`define ADC_RES_BITS 18
`define ADC_RAW_BITS 20
`define ADC_CODE_POS_MAX 18'h1ffff
`define ADC_CODE_NEG_MAX 18'h20000
// falling shift edges before release, without and with start bit
`define ADC_EDGES_PLAIN 5'h12
`define ADC_EDGES_BUSY 5'h13

`endif

//--- common/adc_serial_pkg.sv
// types shared by the converter serial interface
// assumes adc_serial_defines.svh is compiled alongside
package adc_serial_pkg;

  // the three link pins sampled together
  typedef struct packed {
    logic start;
    logic din;
    logic sck;
  } link_pins_s;

  // converter phase, gray coded along acquire -> convert -> powered down
  typedef enum logic [1:0] {
    PH_ACQ  = 2'b00,
    PH_CONV = 2'b01,
    PH_PDN  = 2'b11
  } phase_e;

endpackage

//--- verilog/adc_serial_mode_select.sv
// digital side of an 18-bit sampling converter: mode latch, conversion timer,
// result buffer and serial output shifter.
// assumes link pins are asynchronous to mclk_in and that the shift clock is
// far slower than mclk_in; the converter core estimate arrives on mclk_in.
//
// Functional notes
// - sample data-in at every convert-start rise
// - data-in high selects select-driven, low daisy-chain
// - data-in tied to convert-start gives daisy-chain
// - four-wire mode: data-in selects readback
// - daisy-chain passes data-in through like shift register
// - optional start bit announces finished conversion
// - select mode: busy if either low at end
// - chain mode: busy if shift clock high
// - power down after each conversion phase
// - internal conversion timer, shift clock unused there
// - 18-bit two's complement, clamped at both limits
// - no busy: msb on select, release after 18
// - busy: drive low at end, release after 19
`timescale 1ns/1ps
`include "adc_serial_defines.svh"

module adc_serial_mode_select #(
  parameter int CONV_CYC = `ADC_CONV_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // link pins
  input wire logic convert_start_in,
  input wire logic serial_data_in_in,
  input wire logic shift_clk_in,
  output logic serial_data_out_out,
  output logic serial_data_oe_out,
  // converter core estimate, wider than the code so it can over-range
  input wire logic signed [`ADC_RAW_BITS-1:0] analog_code_in,
  // status
  output logic chain_mode_out,
  output logic busy_en_out,
  output logic converting_out,
  output logic power_down_out
);

  adc_serial_pkg::link_pins_s pins_raw;
  adc_serial_pkg::link_pins_s sync1_r;
  adc_serial_pkg::link_pins_s sync2_r;
  adc_serial_pkg::link_pins_s sync3_r;
  adc_serial_pkg::phase_e phase_r;
  logic start_rise;
  logic sck_fall;
  logic sel_act;
  logic chain_r;
  logic busy_r;
  logic conv_r;
  logic pdn_r;
  logic [15:0] conv_cnt_r;
  logic conv_end;
  logic loaded_r;
  logic load;
  logic [`ADC_RES_BITS:0] shift_r;
  logic [4:0] edge_cnt_r;
  logic [4:0] edge_cnt_nxt;
  logic oe_r;
  logic [`ADC_RES_BITS-1:0] code_clamped;
  logic [`ADC_RES_BITS-1:0] buf_mem [2];
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  logic buf_full;
  logic buf_empty;
  logic buf_wr_valid;
  logic buf_wr_ready;
  logic buf_rd_valid;
  logic buf_rd_ready;
  logic [`ADC_RES_BITS-1:0] buf_rd_data;

  function automatic logic [`ADC_RES_BITS-1:0] clamp_code(
    input logic signed [`ADC_RAW_BITS-1:0] raw
  );
    logic signed [`ADC_RAW_BITS-1:0] hi;
    logic signed [`ADC_RAW_BITS-1:0] lo;
    hi = `ADC_RAW_BITS'(signed'({1'b0, `ADC_CODE_POS_MAX}));
    lo = `ADC_RAW_BITS'(signed'({2'b11, `ADC_CODE_NEG_MAX}));
    if (raw > hi) begin
      clamp_code = `ADC_CODE_POS_MAX;
    end else if (raw < lo) begin
      clamp_code = `ADC_CODE_NEG_MAX;
    end else begin
      clamp_code = raw[`ADC_RES_BITS-1:0];
    end
  endfunction

  // pin synchronisers; the third stage serves edge detection
  assign pins_raw = '{start: convert_start_in, din: serial_data_in_in, sck: shift_clk_in};

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign start_rise = sync2_r.start && !sync3_r.start;
  assign sck_fall = sync3_r.sck && !sync2_r.sck;
  // select active when either pin is low (three- or four-wire)
  assign sel_act = !(sync2_r.start && sync2_r.din);

  // mode latch; data-in is taken one stage late as hold margin
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      chain_r <= 1'b0;
    end else if (start_rise) begin
      chain_r <= !sync3_r.din;
    end
  end

  // busy choice: at the rise for chain mode, at conversion end otherwise
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      busy_r <= 1'b0;
    end else if (start_rise) begin
      busy_r <= !sync3_r.din && sync3_r.sck;
    end else if (conv_end && !chain_r) begin
      busy_r <= sel_act;
    end
  end

  // conversion timer on the system clock only
  assign conv_end = (phase_r == adc_serial_pkg::PH_CONV) && (conv_cnt_r >= 16'(CONV_CYC - 1))
                    && buf_wr_ready;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      phase_r <= adc_serial_pkg::PH_ACQ;
      conv_cnt_r <= '0;
    end else begin
      unique case (phase_r)
        adc_serial_pkg::PH_ACQ, adc_serial_pkg::PH_PDN: begin
          conv_cnt_r <= '0;
          if (start_rise) begin
            phase_r <= adc_serial_pkg::PH_CONV;
          end
        end
        adc_serial_pkg::PH_CONV: begin
          if (conv_cnt_r < 16'(CONV_CYC - 1)) begin
            conv_cnt_r <= conv_cnt_r + 16'h1;
          end
          if (conv_end) begin
            phase_r <= adc_serial_pkg::PH_PDN;
          end
        end
        default: begin
          phase_r <= adc_serial_pkg::PH_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      conv_r <= 1'b0;
      pdn_r <= 1'b0;
    end else begin
      // a start rise inside the conversion phase does not restart it
      conv_r <= (phase_r == adc_serial_pkg::PH_CONV) ? !conv_end : start_rise;
      pdn_r <= (phase_r == adc_serial_pkg::PH_PDN) && !start_rise || conv_end;
    end
  end

  // two-entry result buffer; a full buffer stalls the conversion end
  assign code_clamped = clamp_code(analog_code_in);
  assign buf_wr_valid = (phase_r == adc_serial_pkg::PH_CONV)
                        && (conv_cnt_r >= 16'(CONV_CYC - 1));
  assign buf_full = (wr_ptr_r[1] != rd_ptr_r[1]) && (wr_ptr_r[0] == rd_ptr_r[0]);
  assign buf_empty = wr_ptr_r == rd_ptr_r;
  assign buf_wr_ready = !buf_full;
  assign buf_rd_valid = !buf_empty;
  assign buf_rd_data = buf_mem[rd_ptr_r[0]];
  assign buf_rd_ready = load;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (buf_wr_valid && buf_wr_ready) begin
        wr_ptr_r <= wr_ptr_r + 2'h1;
      end
      if (buf_rd_valid && buf_rd_ready) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (buf_wr_valid && buf_wr_ready) begin
      buf_mem[wr_ptr_r[0]] <= code_clamped;
    end
  end

  // readback: one load per conversion once selected (or at once in chain)
  assign load = (phase_r == adc_serial_pkg::PH_PDN) && !loaded_r && buf_rd_valid
                && !start_rise && (chain_r || sel_act);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      loaded_r <= 1'b0;
    end else if (start_rise) begin
      loaded_r <= 1'b0;
    end else if (load) begin
      loaded_r <= 1'b1;
    end
  end

  assign edge_cnt_nxt = edge_cnt_r + 5'h1;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      shift_r <= '0;
      edge_cnt_r <= '0;
      oe_r <= 1'b0;
    end else if (start_rise) begin
      oe_r <= 1'b0;
    end else if (load) begin
      // start bit low ahead of the result, or msb first
      shift_r <= busy_r ? {1'b0, buf_rd_data} : {buf_rd_data, 1'b0};
      edge_cnt_r <= '0;
      oe_r <= 1'b1;
    end else if (oe_r && chain_r) begin
      if (sck_fall && busy_r) begin
        shift_r <= {shift_r[`ADC_RES_BITS-1:0], sync3_r.din};
      end else if (sck_fall) begin
        // no start bit: the lsb is a spare slot, so data-in enters just above it
        shift_r <= {shift_r[`ADC_RES_BITS-1:1], sync3_r.din, 1'b0};
      end
    end else if (oe_r) begin
      if (!sel_act) begin
        oe_r <= 1'b0;
      end else if (sck_fall) begin
        shift_r <= {shift_r[`ADC_RES_BITS-1:0], 1'b0};
        edge_cnt_r <= edge_cnt_nxt;
        if (edge_cnt_nxt == (busy_r ? `ADC_EDGES_BUSY : `ADC_EDGES_PLAIN)) begin
          oe_r <= 1'b0;
        end
      end
    end
  end

  assign serial_data_out_out = shift_r[`ADC_RES_BITS];
  assign serial_data_oe_out = oe_r;
  assign chain_mode_out = chain_r;
  assign busy_en_out = busy_r;
  assign converting_out = conv_r;
  assign power_down_out = pdn_r;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_cs_load_busy;
    load && busy_r && !chain_r;
  endsequence

  sequence s_start_bit;
    oe_r && !serial_data_out_out;
  endsequence

  a_mode_latch: assert property (start_rise |=> chain_r == !$past(sync3_r.din))
    else $error("mode not latched from data-in at convert rise");
  a_chain_busy: assert property (start_rise && !sync3_r.din |=>
      busy_r == $past(sync3_r.sck))
    else $error("chain busy choice not taken from shift clock");
  a_cs_busy_end: assert property (conv_end && !chain_r |=> busy_r == $past(sel_act))
    else $error("select busy choice wrong at conversion end");
  a_conv_length: assert property ($rose(conv_r) |-> conv_r [*8])
    else $error("conversion phase ended too early");
  a_pdn_follows: assert property (conv_end |=> pdn_r && !conv_r)
    else $error("no power down after conversion");
  a_clamp_high: assert property (analog_code_in > 20'sh1ffff |->
      code_clamped == `ADC_CODE_POS_MAX)
    else $error("positive clamp wrong");
  a_deselect_rel: assert property (oe_r && !chain_r && !sel_act && !start_rise |=> !oe_r)
    else $error("output not released on deselect");
  a_busy_start: assert property (s_cs_load_busy |=> s_start_bit)
    else $error("start bit not driven low");
  a_mode_hold: assert property (!start_rise |=> $stable(chain_r))
    else $error("mode changed without convert rise");
  a_chain_pass: assert property (oe_r && chain_r && sck_fall && !start_rise |=>
      serial_data_out_out == $past(shift_r[`ADC_RES_BITS-1]))
    else $error("chain shift wrong");

endmodule

//--- verification/link_host_model.sv
// host model for the converter link: drives start, data-in and shift clock
// assumes it shares mclk_in with the bench; pins change just after rising edges
`timescale 1ns/1ps
module link_host_model (
  input wire logic mclk_in,
  input wire logic line_in,
  input wire logic oe_in,
  output logic start_out,
  output logic din_out,
  output logic sck_out
);
  // a released data line floats up to its pull-up level
  logic line_seen;
  assign line_seen = oe_in ? line_in : 1'b1;
  initial begin
    start_out = 1'b0;
    din_out = 1'b1;
    sck_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // levels around the start rise, then levels held through the conversion
  task automatic start(input logic din_rise, sck_rise, tie, start_hold, din_hold);
    start_out <= 1'b0;
    din_out <= din_rise & ~tie;
    sck_out <= sck_rise;
    tick(6);
    start_out <= 1'b1;
    if (tie) din_out <= 1'b1;
    tick(4);
    sck_out <= 1'b0;
    start_out <= start_hold;
    din_out <= din_hold | tie;
  endtask
  // select, then clock n bits out msb first, shift clock period 8 cycles
  task automatic read(input int n, input logic start_sel, din_sel, output logic [20:0] bits,
                      output logic oe_end);
    bits = '0;
    start_out <= start_sel;
    din_out <= din_sel;
    tick(6);
    for (int i = n - 1; i >= 0; i--) begin
      bits[i] = line_seen;
      sck_out <= 1'b1;
      tick(4);
      sck_out <= 1'b0;
      tick(4);
    end
    tick(2);
    oe_end = oe_in;
  endtask
endmodule

//--- verification/adc_serial_mode_select_bench.sv
// self-checking bench for the converter mode latch and serial output
// assumes link_host_model plays the host; conversion shortened to 16 cycles
`timescale 1ns/1ps
module adc_serial_mode_select_bench;
  localparam int CC = 16;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic signed [19:0] code = '0;
  logic start_pin, din_pin, sck, dout, oe, chain, busy, conv, pdn, oe_end;
  logic [20:0] bits, e;
  logic [31:0] seed = 32'h00014b46;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [19:0] corner [4] = '{20'h7ffff, 20'h80000, 20'h1ffff, 20'he0000};
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (conv === 1'b1) cyc <= cyc + 1;
  adc_serial_mode_select #(.CONV_CYC(CC)) dut_u (.mclk_in(mclk_in), .srst_in(srst_in),
    .convert_start_in(start_pin), .serial_data_in_in(din_pin), .shift_clk_in(sck),
    .serial_data_out_out(dout), .serial_data_oe_out(oe), .analog_code_in(code),
    .chain_mode_out(chain), .busy_en_out(busy), .converting_out(conv),
    .power_down_out(pdn));
  link_host_model host_u (.mclk_in(mclk_in), .line_in(dout), .oe_in(oe),
    .start_out(start_pin), .din_out(din_pin), .sck_out(sck));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [17:0] clamp(input logic signed [19:0] v);
    if (v > 20'sh1ffff) return 18'h1ffff;
    if (v < 20'she0000) return 18'h20000;
    return v[17:0];
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // k: 0/1 three-wire, 2/3 four-wire, 4/5 chain, 6 data-in tied to start
  task automatic run(input int k);
    logic ch, bz;
    int n;
    ch = (k >= 4);
    bz = (k % 2 == 1);
    n = 18 + bz + (ch ? 2 : 0);
    e = ch ? {1'b0, clamp(code), 2'b11} : 21'(clamp(code));
    cyc = 0;
    host_u.start(~ch, k == 5, k == 6, k != 1, k != 3);
    for (int i = 0; i < 200 && pdn !== 1'b1; i++) @(posedge mclk_in);
    host_u.tick(4);
    check("chain mode", chain, ch);
    check("busy enable", busy, bz);
    check("conversion length", cyc, CC);
    check("powered down", {pdn, conv}, 2'b10);
    check("output enable", oe, bz | ch);
    host_u.read(n, k >= 2, !(k == 2 || k == 3), bits, oe_end);
    check("result bits", bits, e);
    if (!ch) check("release", oe_end, 1'b0);
    check("mode held", {chain, busy}, {ch, bz});
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    host_u.tick(3);
    for (int r = 0; r < 28; r++) begin
      seed = xs(seed);
      code <= r < 4 ? corner[r] : seed[19:0];
      host_u.tick(1);
      run(r % 7);
    end
    complete_run();
  end
  // about 5400 cycles expected; allow several times that
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end
endmodule
